// ===== rtl/pbsp_core.sv
// pipelined burst static memory port with double-cycle deselect
module pbsp_core (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst,
	// address and burst control
	input  wire logic [pbsp_pkg::ADDR_W-1:0]   addr,
	input  wire logic                          proc_addr_strobe_n,
	input  wire logic                          ctrl_addr_strobe_n,
	input  wire logic                          burst_advance_n,
	input  wire logic                          burst_order_linear,
	// chip selects
	input  wire logic                          chip_select_n,
	input  wire logic                          depth_select_hi,
	input  wire logic                          depth_select_lo_n,
	// write controls
	input  wire logic [pbsp_pkg::LANES-1:0]    lane_write_n,
	input  wire logic                          lane_write_master_n,
	input  wire logic                          all_lanes_write_n,
	// asynchronous controls
	input  wire logic                          output_enable_n,
	input  wire logic                          snooze_request,
	// shared data pins, lane a in the low bits, parity at bit 8 of each lane
	input  wire logic [pbsp_pkg::DQ_W-1:0]     dq_in,
	output logic      [pbsp_pkg::DQ_W-1:0]     dq_out,
	output logic                               dq_oe
);
	import pbsp_pkg::*;

	// storage array, one word per address
	// R02 build-time array geometry
	logic [DQ_W-1:0] mem [DEPTH];

	// burst and access state
	logic [ADDR_W-1:0]  base_ff;      // loaded start address
	logic [BURST_W-1:0] cnt_ff;       // burst step count
	logic               sel_ff;       // selects sampled at last load
	logic               rd_ff;        // read address registered
	logic               out_valid_ff; // output register holds read data
	logic               linger_ff;    // extra deselect stage
	logic [DQ_W-1:0]    dout_ff;      // output pipeline register
	// pending self-timed write
	logic               wr_pend_ff;
	logic [ADDR_W-1:0]  wr_addr_ff;
	logic [DQ_W-1:0]    wr_data_ff;
	logic [DQ_W-1:0]    wr_mask_ff;

	// expand a lane mask to data bits; parity only where the build has it
	function automatic logic [DQ_W-1:0] lane_expand(input logic [LANES-1:0] m);
		logic [DQ_W-1:0] r;
		r = '0;
		for (int i = 0; i < LANES; i++) begin
			r[i*LANE_W +: LANE_DATA_W] = {LANE_DATA_W{m[i]}};
			r[i*LANE_W + LANE_DATA_W] = m[i] & HAS_PARITY;
		end
		return r;
	endfunction

	// burst address from start and step count
	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] b,
		input logic [BURST_W-1:0] c, input logic lin);
		logic [BURST_W-1:0] lo;
		lo = lin ? (b[BURST_W-1:0] + c) : (b[BURST_W-1:0] ^ c);
		return {b[ADDR_W-1:BURST_W], lo};
	endfunction

	// bits that the array really keeps
	localparam logic [DQ_W-1:0] STORE_MASK = lane_expand('1);

	// snooze blocks every new load, burst step and access, combinationally; a pending write still commits
	// R16 snooze gates loads, steps and accesses
	wire awake = !snooze_request;
	// all three selects must agree for this device to answer
	// R04 depth selects qualify
	wire sel_now = !chip_select_n & depth_select_hi & !depth_select_lo_n;
	// R17 primary select qualifies proc strobe
	wire proc_load = awake & !proc_addr_strobe_n & !chip_select_n;
	// R08 either strobe starts a burst
	wire ctrl_load = awake & !ctrl_addr_strobe_n;
	wire load      = proc_load | ctrl_load;
	// continuing cycle of a selected burst
	wire cont      = awake & !load & sel_ff;
	// R09 advance steps only inside a burst
	wire advance   = cont & !burst_advance_n;

	// R13 global write overrides lane enables
	wire [LANES-1:0] wr_lanes = !all_lanes_write_n ? '1 :
		(!lane_write_master_n ? ~lane_write_n : '0);
	// R18 writes need a lane request; a proc strobe cycle without the ctrl strobe is always a read
	wire wr_req   = |wr_lanes;
	wire access   = (ctrl_load & sel_now) | cont;
	wire write_go = access & wr_req;
	wire read_go  = ((load & sel_now) | cont) & !write_go;

	// R03 two-bit counter, cleared on load
	wire [BURST_W-1:0] nxt_cnt  = load ? BURST_RST : (advance ? cnt_ff + BURST_ONE : cnt_ff);
	wire [ADDR_W-1:0]  nxt_base = load ? addr : base_ff;
	wire               nxt_sel  = load ? sel_now : sel_ff;
	// R19 R07 only the low bits move, in strap order
	wire [ADDR_W-1:0]  cur_addr = burst_addr(base_ff, cnt_ff, burst_order_linear);
	wire [ADDR_W-1:0]  nxt_addr = burst_addr(nxt_base, nxt_cnt, burst_order_linear);

	// R12 R14 lane mask with parity only on parity builds
	wire [DQ_W-1:0] nxt_wr_mask = lane_expand(wr_lanes);
	// forward a write still waiting for its commit
	wire            hit      = wr_pend_ff & (wr_addr_ff == cur_addr);
	wire [DQ_W-1:0] rd_word  = hit ? ((mem[cur_addr] & ~wr_mask_ff) | (wr_data_ff & wr_mask_ff))
		: mem[cur_addr];
	wire            drive_en = out_valid_ff | linger_ff;

	// R01 burst registers sample on the rising edge
	always_ff @(posedge clock) begin
		if (rst) begin
			base_ff <= ADDR_RST;
			cnt_ff  <= BURST_RST;
			sel_ff  <= 1'b0;
		end else begin
			base_ff <= nxt_base;
			cnt_ff  <= nxt_cnt;
			sel_ff  <= nxt_sel;
		end
	end

	// R10 capture write address, data and lanes
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= ADDR_RST;
			wr_data_ff <= DQ_RST;
			wr_mask_ff <= DQ_RST;
		end else begin
			wr_pend_ff <= write_go;
			if (write_go) begin
				wr_addr_ff <= nxt_addr;
				wr_data_ff <= dq_in & STORE_MASK;
				wr_mask_ff <= nxt_wr_mask;
			end
		end
	end

	// R11 self-timed commit merges only the enabled lanes
	always_ff @(posedge clock) begin
		if (wr_pend_ff) begin
			mem[wr_addr_ff] <= (mem[wr_addr_ff] & ~wr_mask_ff) | (wr_data_ff & wr_mask_ff);
		end
	end

	// R20 output pipeline; read data shows one clock after the address
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_ff        <= 1'b0;
			out_valid_ff <= 1'b0;
			dout_ff      <= DQ_RST;
		end else begin
			rd_ff        <= read_go;
			out_valid_ff <= rd_ff;
			if (rd_ff) begin
				dout_ff <= rd_word & STORE_MASK;
			end
		end
	end

	// R15 extra enable stage; a write turns it off to free the bus
	always_ff @(posedge clock) begin
		if (rst) begin
			linger_ff <= 1'b0;
		end else begin
			linger_ff <= out_valid_ff & !write_go;
		end
	end

	// R05 R06 drivers follow output enable and snooze without the clock
	assign dq_oe  = !output_enable_n & awake & drive_en;
	assign dq_out = dout_ff;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_load_addr;
		load |=> cur_addr == $past(addr);
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("load did not take address"); // R08

	property p_hold;
		cont && burst_advance_n |=> cnt_ff == $past(cnt_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved without advance"); // R09

	property p_wrap;
		!load ##1 !load |-> $stable(cur_addr[ADDR_W-1:BURST_W]);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst left its group of four"); // R19

	property p_linear;
		cont && !burst_advance_n && burst_order_linear ##1 burst_order_linear
		|-> cur_addr[BURST_W-1:0] == $past(cur_addr[BURST_W-1:0]) + BURST_ONE;
	endproperty
	a_linear: assert property (p_linear) else $error("linear step wrong"); // R07

	property p_global;
		write_go && !all_lanes_write_n |=> wr_mask_ff == STORE_MASK && wr_pend_ff;
	endproperty
	a_global: assert property (p_global) else $error("global write missed lanes"); // R13

	property p_lane_read;
		all_lanes_write_n && (lane_write_master_n || &lane_write_n) && access |-> read_go && !write_go;
	endproperty
	a_lane_read: assert property (p_lane_read) else $error("write without lane request"); // R18

	property p_oe_off;
		output_enable_n || snooze_request |-> !dq_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drivers on while disabled"); // R06

	property p_snooze;
		snooze_request |=> $stable(base_ff) && $stable(cnt_ff) && !rd_ff && !wr_pend_ff;
	endproperty
	a_snooze: assert property (p_snooze) else $error("input acted during snooze"); // R16

	property p_read_lat;
		read_go |=> ##1 out_valid_ff;
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("read data not after one clock"); // R20

	property p_double;
		out_valid_ff && !write_go ##1 !out_valid_ff |-> drive_en;
	endproperty
	a_double: assert property (p_double) else $error("drivers off too early"); // R15

	property p_proc_ce;
		!proc_addr_strobe_n && chip_select_n && ctrl_addr_strobe_n |-> !load;
	endproperty
	a_proc_ce: assert property (p_proc_ce) else $error("proc strobe taken unselected"); // R17

	c_burst4: cover property (load && sel_now ##1 advance [*3]);
	c_write: cover property (write_go ##1 wr_pend_ff ##1 read_go);
	c_deselect: cover property (out_valid_ff ##1 !out_valid_ff && linger_ff);
	c_snooze: cover property (sel_ff && snooze_request ##1 !snooze_request);
endmodule

// ===== inc/pbsp_pkg.sv
// constants for the pipelined burst static memory port
// Operation
// R01: capture all synchronous inputs on rising clock
// R02: array is 128Kx18, 64Kx32 or 64Kx36
// R03: two-bit burst address counter
// R04: two extra depth selects, one each polarity
// R05: output enable and snooze act asynchronously
// R06: drive data only while output enable asserted
// R07: strap picks interleaved or linear burst order
// R08: either address strobe loads a new burst
// R09: advance input steps address, else hold
// R10: registered write completes self-timed internally
// R11: write any subset of byte lanes
// R12: each lane enable gates data plus parity
// R13: global write low writes every lane
// R14: parity only on 18 and 36 bit builds
// R15: drivers stay on one cycle past deselect
// R16: snooze retains contents, ignores other inputs
// R17: selects sampled at load, primary qualifies proc strobe
// R18: master lane enable low permits lane writes
// R19: burst wraps inside aligned group of four
// R20: read data through one pipeline register
package pbsp_pkg;

	// build configurations of the array
	localparam int CFG_X18 = 0;
	localparam int CFG_X32 = 1;
	localparam int CFG_X36 = 2;
	localparam int CFG     = CFG_X36;

	// derived geometry
	localparam int LANES       = (CFG == CFG_X18) ? 2 : 4;
	localparam bit HAS_PARITY  = (CFG != CFG_X32);
	localparam int LANE_DATA_W = 8;
	localparam int LANE_W      = LANE_DATA_W + 1;
	localparam int DQ_W        = LANES * LANE_W;
	localparam int ADDR_W      = (CFG == CFG_X18) ? 17 : 16;
	localparam int DEPTH       = 1 << ADDR_W;

	// burst counter
	localparam int              BURST_W   = 2;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

	// reset values of control state
	localparam logic [ADDR_W-1:0] ADDR_RST = '0;
	localparam logic [DQ_W-1:0]   DQ_RST   = '0;

endpackage

// ===== bench/pbsp_master.sv
// bus master model that drives the memory port off the falling clock edge
module pbsp_master (
	// clock
	input  wire logic                     clock,
	// strobes, select and advance
	output logic                          ctrl_addr_strobe_n,
	output logic                          proc_addr_strobe_n,
	output logic                          chip_select_n,
	output logic                          burst_advance_n,
	// address, write data and write controls
	output logic [pbsp_pkg::ADDR_W-1:0]   addr,
	output logic [pbsp_pkg::DQ_W-1:0]     dq_in,
	output logic [pbsp_pkg::LANES-1:0]    lane_write_n,
	output logic                          lane_write_master_n,
	output logic                          all_lanes_write_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import pbsp_pkg::*;
	// one bus cycle, launched after the falling edge so it is stable at the rising edge
	// held a full cycle
	task automatic put(input logic c, p, s, v, input logic [ADDR_W-1:0] a, input logic g, w,
		input logic [LANES-1:0] l, input logic [DQ_W-1:0] d);
		@(negedge clock);
		{ctrl_addr_strobe_n, proc_addr_strobe_n, chip_select_n, burst_advance_n} = {c, p, s, v};
		{addr, all_lanes_write_n, lane_write_master_n, lane_write_n} = {a, g, w, l};
		// released data lines toggle, so stale write data is never read as a match
		dq_in = (!g || !w) ? d : ~dq_in;
	endtask
	// idle bus from time zero
	initial begin
		{ctrl_addr_strobe_n, proc_addr_strobe_n, chip_select_n, burst_advance_n} = 4'hF;
		{addr, all_lanes_write_n, lane_write_master_n, lane_write_n, dq_in} = '1;
	end
endmodule

// ===== bench/pipelined_burst_sram_port_tb.sv
// self-checking bench for the pipelined burst memory port
module pipelined_burst_sram_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pbsp_pkg::*;
	logic clock = 0, rst = 1, burst_order_linear = 0, output_enable_n = 0, snooze_request = 0;
	logic depth_select_hi = 1, depth_select_lo_n = 0, dq_oe;
	logic ctrl_addr_strobe_n, proc_addr_strobe_n, chip_select_n, burst_advance_n;
	logic lane_write_master_n, all_lanes_write_n;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] dq_in, dq_out;
	logic [LANES-1:0] lane_write_n;
	logic [DQ_W-1:0] mem [int]; // expected array contents
	logic [31:0] seed = 32'h40;
	int mismatches = 0, n_tests = 0, cycles = 0;
	initial begin
		forever #50 clock = ~clock;
	end
	pbsp_core DUT (
		.clock               (clock),
		.rst                 (rst),
		.addr                (addr),
		.proc_addr_strobe_n  (proc_addr_strobe_n),
		.ctrl_addr_strobe_n  (ctrl_addr_strobe_n),
		.burst_advance_n     (burst_advance_n),
		.burst_order_linear  (burst_order_linear),
		.chip_select_n       (chip_select_n),
		.depth_select_hi     (depth_select_hi),
		.depth_select_lo_n   (depth_select_lo_n),
		.lane_write_n        (lane_write_n),
		.lane_write_master_n (lane_write_master_n),
		.all_lanes_write_n   (all_lanes_write_n),
		.output_enable_n     (output_enable_n),
		.snooze_request      (snooze_request),
		.dq_in               (dq_in),
		.dq_out              (dq_out),
		.dq_oe               (dq_oe)
	);
	pbsp_master m (
		.clock               (clock),
		.ctrl_addr_strobe_n  (ctrl_addr_strobe_n),
		.proc_addr_strobe_n  (proc_addr_strobe_n),
		.chip_select_n       (chip_select_n),
		.burst_advance_n     (burst_advance_n),
		.addr                (addr),
		.dq_in               (dq_in),
		.lane_write_n        (lane_write_n),
		.lane_write_master_n (lane_write_master_n),
		.all_lanes_write_n   (all_lanes_write_n)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// i-th address of a burst, wrapping inside the aligned group of four
	function automatic logic [ADDR_W-1:0] step(logic [ADDR_W-1:0] a, int i);
		return {a[ADDR_W-1:2], burst_order_linear ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i)};
	endfunction
	function automatic logic [DQ_W-1:0] merge(logic [DQ_W-1:0] o, d, logic [LANES-1:0] l);
		for (int i = 0; i < LANES; i++) begin
			if (!l[i]) o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
		end
		return o;
	endfunction
	task automatic cmp_data(logic [DQ_W-1:0] e, g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_flag(logic e, g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far above the roughly 165 cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	// snooze changes with the write it is meant to cover, so the edge before stays awake
	task automatic wr(logic [ADDR_W-1:0] a, logic [DQ_W-1:0] d, logic g, logic [LANES-1:0] l, logic z);
		m.put(0, 1, 0, 1, a, g, !g, l, d);
		snooze_request = z;
		if (!z) mem[a] = g ? merge(mem[a], d, l) : d;
	endtask
	// burst read of five words, the fifth checks the wrap
	task automatic rd(logic [ADDR_W-1:0] a, logic p);
		m.put(p, !p, 0, 1, a, 1, 1, '1, '0);
		m.put(1, 1, 0, 0, a, 1, 1, '1, '0);
		// mid-burst, an unqualified processor strobe and a raised chip select must not disturb it
		for (int i = 0; i < 5; i++) begin
			m.put(1, i != 2, i == 2, 0, a, 1, 1, '1, '0);
			cmp_data(mem[step(a, i)], dq_out);
			cmp_flag(!output_enable_n, dq_oe);
		end
	endtask
	initial begin
		logic [ADDR_W-1:0] b;
		logic [DQ_W-1:0]   d;
		repeat (4) @(posedge clock);
		@(negedge clock) rst = 0;
		cmp_flag(0, dq_oe);
		for (int j = 0; j < 8; j++) begin
			b = ADDR_W'(rnd());
			b[1:0] = 2'h0;
			burst_order_linear = j[0];
			output_enable_n = j[1];
			for (int i = 0; i < 4; i++) wr(b + ADDR_W'(i), DQ_W'({rnd(), rnd()}), 0, LANES'(rnd()), 0);
			// burst write in a continuing cycle lands on the advanced address
			d = DQ_W'({rnd(), rnd()});
			m.put(1, 1, 0, 0, b, 0, 1, '1, d);
			mem[step(b + ADDR_W'(3), 1)] = d;
			// on pass 5 only, snooze covers the next write, which must leave the array alone
			wr(b + ADDR_W'(j % 4), DQ_W'({rnd(), rnd()}), 1, LANES'(rnd()), j == 5);
			m.put(1, 1, 0, 1, b, 1, 1, '1, '0);
			cmp_flag(0, dq_oe);
			snooze_request = 0;
			rd(b + ADDR_W'(rnd() % 4), j[2]);
			// deselect through one of the depth selects, then an unqualified processor strobe
			{depth_select_hi, depth_select_lo_n} = j[0] ? 2'b00 : 2'b11;
			m.put(0, 1, 0, 1, b, 1, 1, '1, '0);
			for (int i = 0; i < 5; i++) begin
				m.put(1, i != 2, 1, 1, b, 1, 1, '1, '0);
				cmp_flag(!output_enable_n && i < 2, dq_oe);
			end
			{depth_select_hi, depth_select_lo_n} = 2'b10;
		end
		give_verdict();
	end
endmodule
